// *** rtl/prot_pkg.sv ***
package prot_pkg;

  localparam logic [13:0] DISABLE_CODE       = 14'h270F;
  localparam logic [2:0]  BC_NONE            = 3'h0;
  localparam logic [2:0]  BC_DUTY_CHANGE     = 3'h1;
  localparam logic [2:0]  BC_CONV_SHUTOFF    = 3'h3;
  localparam logic [2:0]  BC_CONV_IPF        = 3'h4;
  localparam logic [6:0]  BRAKE_DUTY_MAX     = 7'h1E;
  localparam logic [2:0]  TLM_ANALOG         = 3'h1;
  localparam logic [2:0]  TLM_OPTION         = 3'h2;
  localparam logic [2:0]  TLM_PARAM_QUAD     = 3'h3;
  localparam logic [2:0]  TLM_PARAM_FOUR     = 3'h4;
  localparam logic [2:0]  TLM_RESET          = 3'h3;
  localparam logic [13:0] TORQUE_MAX         = 14'h0190;
  localparam logic [13:0] TORQUE_MAIN_RESET  = 14'h0096;
  localparam logic [13:0] OVERSPEED_RESET    = 14'h0BB8;
  localparam logic [1:0]  LINK_START_AUTO    = 2'h2;
  localparam logic [7:0]  OVERSPEED_NUM      = 8'h73;
  localparam logic [7:0]  OVERSPEED_DEN      = 8'h64;
  localparam int          STOP_TIME_US       = 3000;
  localparam int          CLK_MHZ            = 250;
  localparam int          STOP_CYCLES        = (STOP_TIME_US * CLK_MHZ);
  localparam int          MS_TICK_CYCLES     = 250000;

  typedef enum logic [1:0] {
    Q_FWD_DRIVE = 2'b00,
    Q_FWD_REGEN = 2'b01,
    Q_REV_DRIVE = 2'b10,
    Q_REV_REGEN = 2'b11
  } quadrant_t;

  typedef enum logic [1:0] {
    PH_CONST = 2'b00,
    PH_ACCEL = 2'b01,
    PH_DECEL = 2'b10
  } phase_t;

  typedef struct packed {
    logic [2:0]  brake_converter_select;
    logic [6:0]  regen_brake_duty;
    logic [13:0] speed_dev_level;
    logic [13:0] speed_dev_time;
    logic [13:0] overspeed_level;
    logic [2:0]  torque_limit_mode;
    logic [13:0] torque_limit_main;
    logic [13:0] torque_limit_regen;
    logic [13:0] torque_limit_q3;
    logic [13:0] torque_limit_q4;
    logic [13:0] torque_limit_second;
    logic [13:0] decel_torque_limit;
    logic [13:0] accel_torque_limit;
    logic [1:0]  link_start_mode;
    logic [13:0] restart_coast_time;
  } params_t;

endpackage

// *** rtl/min3.sv ***
`timescale 1ns/1ps
module min3
  import prot_pkg::*;
#(
  parameter int W = 14
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic [W-1:0] c,
  output logic      [W-1:0] y
);
  logic [W-1:0] ab;
  assign ab = (a < b) ? a : b;
  assign y  = (ab < c) ? ab : c;
endmodule

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
  import prot_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule

// *** rtl/drive_protection_torque_limit.sv ***
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module drive_protection_torque_limit
  import prot_pkg::*;
#(
  parameter int DEV_TICK_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        small_model,
  input  wire logic        torque_control,
  input  wire logic        vf_control,
  input  wire logic        panel_operation,
  input  wire logic        shutoff_input,
  input  wire logic        power_fail_input,
  input  wire logic        mains_voltage_present,
  input  wire logic        undervoltage_raw,
  input  wire logic        power_fail_raw,
  input  wire logic        torque_limit_select_input,
  input  wire logic        run_cmd,
  input  wire logic [13:0] speed_cmd,
  input  wire logic [13:0] speed_act,
  input  wire logic [13:0] analog3_abs,
  input  wire logic [13:0] analog4,
  input  wire logic        option_fitted,
  input  wire logic [1:0]  quadrant,
  input  wire logic [1:0]  phase,
  output logic             run_enable,
  output logic             brake_enable,
  output logic             undervoltage_detect,
  output logic             power_fail_detect,
  output logic             option_error,
  output logic             speed_dev_error,
  output logic             overspeed_error,
  output logic             stored_run_cmd,
  output logic             duty_visible,
  output logic      [13:0] torque_limit
);

  localparam logic [4:0] A_BCSEL = 5'h00;
  localparam logic [4:0] A_DUTY  = 5'h01;
  localparam logic [4:0] A_DEVL  = 5'h02;
  localparam logic [4:0] A_DEVT  = 5'h03;
  localparam logic [4:0] A_OSL   = 5'h04;
  localparam logic [4:0] A_TLM   = 5'h05;
  localparam logic [4:0] A_TLMN  = 5'h06;
  localparam logic [4:0] A_TLRG  = 5'h07;
  localparam logic [4:0] A_TLQ3  = 5'h08;
  localparam logic [4:0] A_TLQ4  = 5'h09;
  localparam logic [4:0] A_TL2   = 5'h0A;
  localparam logic [4:0] A_DECL  = 5'h0B;
  localparam logic [4:0] A_ACCL  = 5'h0C;
  localparam logic [4:0] A_LINK  = 5'h0D;
  localparam logic [4:0] A_COAST = 5'h0E;
  localparam logic [4:0] A_STAT  = 5'h0F;
  localparam logic [4:0] A_CLEAR = 5'h10;
  localparam logic [4:0] A_LIMIT = 5'h11;

  typedef struct packed {
    params_t     p;
    logic [15:0] rdata;
    logic [31:0] stop_cnt;
    logic        run_en;
    logic [31:0] tick_cnt;
    logic [13:0] dev_ms;
    logic [9:0]  dev_sub;
    logic        dev_err;
    logic        os_err;
    logic        opt_err;
    logic        stored;
    logic [13:0] limit;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic        shutoff_s;
  logic        pfail_s;
  logic        mains_s;
  logic        tlsel_s;
  logic        conv_mode;
  logic [13:0] lvl_regen;
  logic [13:0] lvl_q3;
  logic [13:0] lvl_q4;
  logic [13:0] quad_lvl;
  logic [13:0] param_lvl;
  logic [13:0] analog_lvl;
  logic [13:0] phase_lvl;
  logic [13:0] const_lvl;
  logic [13:0] min_out;
  logic [13:0] spd_diff;
  logic [21:0] os_lhs;
  logic [21:0] os_rhs;

  pin_sync #(.W(4)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({shutoff_input, power_fail_input, mains_voltage_present, torque_limit_select_input}),
    .q     ({shutoff_s, pfail_s, mains_s, tlsel_s})
  );

  // Levels above the maximum are cut to it; the fallback code is kept as is.
  function automatic logic [13:0] clamp_lvl(input logic [15:0] v);
    if (v[13:0] == DISABLE_CODE) begin
      clamp_lvl = DISABLE_CODE;
    end else if (v[13:0] > TORQUE_MAX) begin
      clamp_lvl = TORQUE_MAX;
    end else begin
      clamp_lvl = v[13:0];
    end
  endfunction

  assign conv_mode = (st_ff.p.brake_converter_select == BC_CONV_SHUTOFF) ||
                     (st_ff.p.brake_converter_select == BC_CONV_IPF);

  // Fallback chain for unset quadrant levels.
  always_comb begin
    lvl_regen = (st_ff.p.torque_limit_regen == DISABLE_CODE) ? st_ff.p.torque_limit_main
                                                             : st_ff.p.torque_limit_regen;
    lvl_q3    = (st_ff.p.torque_limit_q3 == DISABLE_CODE) ? st_ff.p.torque_limit_main
                                                          : st_ff.p.torque_limit_q3;
    lvl_q4    = (st_ff.p.torque_limit_q4 == DISABLE_CODE) ? lvl_regen : st_ff.p.torque_limit_q4;
    case (quadrant)
      Q_FWD_DRIVE: quad_lvl = st_ff.p.torque_limit_main;
      Q_FWD_REGEN: quad_lvl = lvl_regen;
      Q_REV_DRIVE: quad_lvl = lvl_q3;
      Q_REV_REGEN: quad_lvl = lvl_q4;
      default:     quad_lvl = st_ff.p.torque_limit_main;
    endcase
    // Analog modes pair the main level with a terminal; mode 4 uses main and regeneration only.
    case (st_ff.p.torque_limit_mode)
      TLM_ANALOG:     param_lvl = st_ff.p.torque_limit_main;
      TLM_OPTION:     param_lvl = st_ff.p.torque_limit_main;
      TLM_PARAM_FOUR: param_lvl = quadrant[0] ? lvl_regen : st_ff.p.torque_limit_main;
      default:        param_lvl = quad_lvl;
    endcase
    if (tlsel_s && st_ff.p.torque_limit_second != DISABLE_CODE) begin
      param_lvl = st_ff.p.torque_limit_second;
    end
    // Analog terminals never raise the limit above the parameter level.
    case (st_ff.p.torque_limit_mode)
      TLM_ANALOG: analog_lvl = analog3_abs;
      TLM_OPTION: analog_lvl = (quadrant[0] && option_fitted) ? analog4 : analog3_abs;
      default:    analog_lvl = TORQUE_MAX;
    endcase
    // A phase limit left at the fallback code keeps the constant-speed limit in force.
    case (phase)
      PH_ACCEL: phase_lvl = (st_ff.p.accel_torque_limit == DISABLE_CODE) ? TORQUE_MAX
                                                                        : st_ff.p.accel_torque_limit;
      PH_DECEL: phase_lvl = (st_ff.p.decel_torque_limit == DISABLE_CODE) ? TORQUE_MAX
                                                                        : st_ff.p.decel_torque_limit;
      default:  phase_lvl = TORQUE_MAX;
    endcase
    const_lvl = param_lvl;
  end

  min3 #(.W(14)) u_min (
    .a (phase_lvl),
    .b (const_lvl),
    .c (analog_lvl),
    .y (min_out)
  );

  // Absolute speed difference without a signed subtract.
  assign spd_diff = (speed_cmd > speed_act) ? (speed_cmd - speed_act) : (speed_act - speed_cmd);
  assign os_lhs   = 22'(speed_act) * 22'(OVERSPEED_DEN);
  assign os_rhs   = 22'(st_ff.p.overspeed_level) * 22'(OVERSPEED_NUM);

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 16'h0000;
    if (wr) begin
      case (addr)
        A_BCSEL: nxt_st.p.brake_converter_select = wdata[2:0];
        A_DUTY: begin
          // Small models clamp to 30 percent; large models stay at zero.
          if (st_ff.p.brake_converter_select == BC_DUTY_CHANGE && small_model) begin
            nxt_st.p.regen_brake_duty = (wdata[6:0] > BRAKE_DUTY_MAX) ? BRAKE_DUTY_MAX : wdata[6:0];
          end
        end
        A_DEVL:  nxt_st.p.speed_dev_level     = wdata[13:0];
        A_DEVT:  nxt_st.p.speed_dev_time      = wdata[13:0];
        A_OSL:   nxt_st.p.overspeed_level     = wdata[13:0];
        A_TLM:   nxt_st.p.torque_limit_mode   = wdata[2:0];
        A_TLMN:  nxt_st.p.torque_limit_main   = (wdata[13:0] > TORQUE_MAX) ? TORQUE_MAX : wdata[13:0];
        A_TLRG:  nxt_st.p.torque_limit_regen  = clamp_lvl(wdata);
        A_TLQ3:  nxt_st.p.torque_limit_q3     = clamp_lvl(wdata);
        A_TLQ4:  nxt_st.p.torque_limit_q4     = clamp_lvl(wdata);
        A_TL2:   nxt_st.p.torque_limit_second = clamp_lvl(wdata);
        A_DECL:  nxt_st.p.decel_torque_limit  = clamp_lvl(wdata);
        A_ACCL:  nxt_st.p.accel_torque_limit  = clamp_lvl(wdata);
        A_LINK:  nxt_st.p.link_start_mode     = wdata[1:0];
        A_COAST: nxt_st.p.restart_coast_time  = wdata[13:0];
        default: nxt_st.p = st_ff.p;
      endcase
    end
    // Large models hold the duty at zero whatever was stored before.
    if (!small_model) begin
      nxt_st.p.regen_brake_duty = 7'h00;
    end
    if (rd) begin
      case (addr)
        A_BCSEL: nxt_st.rdata = {13'h0000, st_ff.p.brake_converter_select};
        A_DUTY:  nxt_st.rdata = (st_ff.p.brake_converter_select == BC_NONE) ? 16'h0000
                                : {9'h000, st_ff.p.regen_brake_duty};
        A_DEVL:  nxt_st.rdata = {2'h0, st_ff.p.speed_dev_level};
        A_DEVT:  nxt_st.rdata = {2'h0, st_ff.p.speed_dev_time};
        A_OSL:   nxt_st.rdata = {2'h0, st_ff.p.overspeed_level};
        A_TLM:   nxt_st.rdata = {13'h0000, st_ff.p.torque_limit_mode};
        A_TLMN:  nxt_st.rdata = {2'h0, st_ff.p.torque_limit_main};
        A_TLRG:  nxt_st.rdata = {2'h0, st_ff.p.torque_limit_regen};
        A_TLQ3:  nxt_st.rdata = {2'h0, st_ff.p.torque_limit_q3};
        A_TLQ4:  nxt_st.rdata = {2'h0, st_ff.p.torque_limit_q4};
        A_TL2:   nxt_st.rdata = {2'h0, st_ff.p.torque_limit_second};
        A_DECL:  nxt_st.rdata = {2'h0, st_ff.p.decel_torque_limit};
        A_ACCL:  nxt_st.rdata = {2'h0, st_ff.p.accel_torque_limit};
        A_LINK:  nxt_st.rdata = {14'h0000, st_ff.p.link_start_mode};
        A_COAST: nxt_st.rdata = {2'h0, st_ff.p.restart_coast_time};
        A_STAT:  nxt_st.rdata = {9'h000, st_ff.stored, st_ff.opt_err, st_ff.os_err, st_ff.dev_err,
                                 st_ff.run_en, pfail_s, shutoff_s};
        A_LIMIT: nxt_st.rdata = {2'h0, st_ff.limit};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end

    // In converter modes a high shut-off input stops running; stop follows three clocks later, well within 3 ms.
    if (conv_mode && shutoff_s) begin
      nxt_st.run_en = 1'b0;
    end else begin
      nxt_st.run_en = run_cmd && !st_ff.dev_err && !st_ff.os_err && !st_ff.opt_err;
    end
    nxt_st.stop_cnt = 32'h0000_0000;

    // Clear goes first so that a trip in the same cycle still wins.
    if (wr && addr == A_CLEAR) begin
      nxt_st.dev_err = 1'b0;
      nxt_st.os_err  = 1'b0;
      nxt_st.opt_err = 1'b0;
    end

    if (conv_mode && mains_s) begin
      nxt_st.opt_err = 1'b1;
    end

    // Run command kept for restart only; never a power-fail trip.
    if (st_ff.p.brake_converter_select == BC_CONV_IPF && st_ff.p.link_start_mode == LINK_START_AUTO &&
        st_ff.p.restart_coast_time != DISABLE_CODE && !pfail_s) begin
      nxt_st.stored = run_cmd;
    end

    // Millisecond time base for the deviation timer.
    if (st_ff.tick_cnt >= 32'(DEV_TICK_CYCLES - 1)) begin
      nxt_st.tick_cnt = 32'h0000_0000;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
    end
    if (st_ff.p.speed_dev_level == DISABLE_CODE || torque_control ||
        spd_diff <= st_ff.p.speed_dev_level) begin
      nxt_st.dev_ms  = 14'h0000;
      nxt_st.dev_sub = 10'h000;
    end else if (st_ff.tick_cnt >= 32'(DEV_TICK_CYCLES - 1)) begin
      if (st_ff.dev_sub >= 10'h3E7) begin
        nxt_st.dev_sub = 10'h000;
        if (st_ff.dev_ms >= st_ff.p.speed_dev_time) begin
          nxt_st.dev_err = 1'b1;
        end else begin
          nxt_st.dev_ms = st_ff.dev_ms + 14'h0001;
        end
      end else begin
        nxt_st.dev_sub = st_ff.dev_sub + 10'h001;
      end
    end

    // Speed times 100 against level times 115 avoids a divider.
    if (!vf_control && os_lhs >= os_rhs) begin
      nxt_st.os_err = 1'b1;
    end

    nxt_st.limit = (phase == PH_CONST) ? ((const_lvl < analog_lvl) ? const_lvl : analog_lvl)
                                       : min_out;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff                          <= '0;
      st_ff.p.speed_dev_level        <= DISABLE_CODE;
      st_ff.p.speed_dev_time         <= 14'h000C;
      st_ff.p.overspeed_level        <= OVERSPEED_RESET;
      st_ff.p.torque_limit_mode      <= TLM_RESET;
      st_ff.p.torque_limit_main      <= TORQUE_MAIN_RESET;
      st_ff.p.torque_limit_regen     <= DISABLE_CODE;
      st_ff.p.torque_limit_q3        <= DISABLE_CODE;
      st_ff.p.torque_limit_q4        <= DISABLE_CODE;
      st_ff.p.torque_limit_second    <= DISABLE_CODE;
      st_ff.p.decel_torque_limit     <= DISABLE_CODE;
      st_ff.p.accel_torque_limit     <= DISABLE_CODE;
      st_ff.limit                    <= TORQUE_MAIN_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata               = st_ff.rdata;
  assign run_enable          = st_ff.run_en;
  // In converter modes the external converter owns these functions.
  assign brake_enable        = !conv_mode;
  assign undervoltage_detect = !conv_mode && undervoltage_raw;
  assign power_fail_detect   = !conv_mode && power_fail_raw;
  assign option_error        = st_ff.opt_err;
  assign speed_dev_error     = st_ff.dev_err;
  assign overspeed_error     = st_ff.os_err;
  assign stored_run_cmd      = st_ff.stored;
  assign duty_visible        = (st_ff.p.brake_converter_select != BC_NONE);
  assign torque_limit        = st_ff.limit;

endmodule

// *** sim/conv_model.sv ***
`timescale 1ns/1ps
module conv_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic not_ready,
  input  wire logic ipf,
  output logic      shutoff_input,
  output logic      power_fail_input
);
  // The converter holds its shut-off line high while the drive must not run.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutoff_input    <= 1'b0;
      power_fail_input <= 1'b0;
    end else begin
      shutoff_input    <= not_ready;
      power_fail_input <= ipf;
    end
  end
endmodule

// *** sim/prot_assertions.sv ***
`timescale 1ns/1ps
module prot_checker
  import prot_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        vf_control,
  input wire logic        shutoff_input,
  input wire logic        mains_voltage_present,
  input wire logic        undervoltage_raw,
  input wire logic        power_fail_raw,
  input wire logic [13:0] speed_act,
  input wire logic        run_enable,
  input wire logic        brake_enable,
  input wire logic        undervoltage_detect,
  input wire logic        power_fail_detect,
  input wire logic        option_error,
  input wire logic        overspeed_error,
  input wire logic        duty_visible,
  input wire logic [13:0] torque_limit
);
  logic [2:0]  sel_ff;
  logic [13:0] os_ff;
  logic [13:0] main_ff;
  logic        conv;
  logic        os_hit;
  assign conv = (sel_ff == BC_CONV_SHUTOFF) || (sel_ff == BC_CONV_IPF);
  assign os_hit = 24'(speed_act) * 24'(OVERSPEED_DEN) >= 24'(os_ff) * 24'(OVERSPEED_NUM);
  // Shadow copies of the registers that the properties depend on.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff  <= BC_NONE;
      os_ff   <= OVERSPEED_RESET;
      main_ff <= TORQUE_MAIN_RESET;
    end else begin
      if (wr && addr == 5'h00) sel_ff <= wdata[2:0];
      if (wr && addr == 5'h04) os_ff <= wdata[13:0];
      if (wr && addr == 5'h06) main_ff <= (wdata[13:0] > TORQUE_MAX) ? TORQUE_MAX : wdata[13:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_duty_hidden: assert property (
    duty_visible == (sel_ff != BC_NONE)) else $error("duty visibility wrong");
  a_conv_masks: assert property (
    conv |-> !brake_enable && !undervoltage_detect && !power_fail_detect) else $error("detector not masked");
  a_detect_pass: assert property (
    !conv |-> undervoltage_detect == undervoltage_raw && power_fail_detect == power_fail_raw)
    else $error("detector not passed through");
  a_shutoff_stop: assert property (
    (conv && shutoff_input) [*4] |-> !run_enable) else $error("run kept after shutoff");
  a_option_err: assert property (
    (conv && mains_voltage_present) [*4] |-> option_error) else $error("option error missing");
  a_os_trip: assert property (
    os_hit && !vf_control |-> ##[1:3] overspeed_error) else $error("overspeed not raised");
  a_os_sticky: assert property (
    overspeed_error && !(wr && addr == 5'h10) |=> overspeed_error) else $error("overspeed dropped");
  a_rd_main: assert property (
    rd && addr == 5'h06 |=> rdata == {2'h0, $past(main_ff)}) else $error("main level read wrong");
  a_rdata_idle: assert property (
    !$past(rd) |-> rdata == 16'h0) else $error("read data not idle");
  a_limit_cap: assert property (
    torque_limit <= TORQUE_MAX) else $error("limit above maximum");
endmodule
bind drive_protection_torque_limit prot_checker u_chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .vf_control(vf_control), .shutoff_input(shutoff_input), .mains_voltage_present(mains_voltage_present),
  .undervoltage_raw(undervoltage_raw), .power_fail_raw(power_fail_raw), .speed_act(speed_act),
  .run_enable(run_enable), .brake_enable(brake_enable), .undervoltage_detect(undervoltage_detect),
  .power_fail_detect(power_fail_detect), .option_error(option_error), .overspeed_error(overspeed_error),
  .duty_visible(duty_visible), .torque_limit(torque_limit)
);

// *** sim/test_drive_protection_torque_limit.sv ***
`timescale 1ns/1ps
module test_drive_protection_torque_limit;
  import prot_pkg::*;
  logic        clk, rst_n, wr, rd, small_model, torque_control, vf_control, panel_operation;
  logic        mains_voltage_present, undervoltage_raw, power_fail_raw, torque_limit_select_input;
  logic        run_cmd, option_fitted, not_ready, ipf, shutoff_input, power_fail_input;
  logic        run_enable, brake_enable, undervoltage_detect, power_fail_detect, option_error;
  logic        speed_dev_error, overspeed_error, stored_run_cmd, duty_visible;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic [13:0] speed_cmd, speed_act, analog3_abs, analog4, torque_limit;
  logic [13:0] p_main, p_regen, p_q3, p_q4, p_sec, p_acc, p_dec;
  logic [2:0]  m;
  logic [1:0]  quadrant, phase;
  int          seed = 32'h45DCCB75;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  drive_protection_torque_limit #(.DEV_TICK_CYCLES(10)) u_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .small_model(small_model), .torque_control(torque_control), .vf_control(vf_control),
    .panel_operation(panel_operation), .shutoff_input(shutoff_input), .power_fail_input(power_fail_input),
    .mains_voltage_present(mains_voltage_present), .undervoltage_raw(undervoltage_raw),
    .power_fail_raw(power_fail_raw), .torque_limit_select_input(torque_limit_select_input),
    .run_cmd(run_cmd), .speed_cmd(speed_cmd), .speed_act(speed_act), .analog3_abs(analog3_abs),
    .analog4(analog4), .option_fitted(option_fitted), .quadrant(quadrant), .phase(phase),
    .run_enable(run_enable), .brake_enable(brake_enable), .undervoltage_detect(undervoltage_detect),
    .power_fail_detect(power_fail_detect), .option_error(option_error), .speed_dev_error(speed_dev_error),
    .overspeed_error(overspeed_error), .stored_run_cmd(stored_run_cmd), .duty_visible(duty_visible),
    .torque_limit(torque_limit)
  );
  conv_model u_conv (
    .clk(clk), .rst_n(rst_n), .not_ready(not_ready), .ipf(ipf),
    .shutoff_input(shutoff_input), .power_fail_input(power_fail_input)
  );

  task automatic conclude();
    $display("mismatches %0d, checks %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // Waits whole cycles, then steps off the edge so outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  function automatic logic [13:0] rv();
    logic [31:0] r;
    r = $random(seed);
    return (r[1:0] == 2'h0) ? DISABLE_CODE : 14'(r[15:2] % 14'h191);
  endfunction
  function automatic logic [13:0] lvl(input logic [13:0] v, input logic [13:0] fb);
    return (v == DISABLE_CODE) ? fb : v;
  endfunction
  function automatic logic [13:0] mn(input logic [13:0] a, input logic [13:0] b);
    return (a < b) ? a : b;
  endfunction
  function automatic logic [13:0] exp_lim();
    logic [13:0] rg, p;
    rg = lvl(p_regen, p_main);
    case (m)
      TLM_ANALOG: p = mn(p_main, analog3_abs);
      TLM_OPTION: p = mn(p_main, (quadrant[0] && option_fitted) ? analog4 : analog3_abs);
      TLM_PARAM_FOUR: p = quadrant[0] ? rg : p_main;
      default: p = quadrant == 2'h0 ? p_main : quadrant == 2'h1 ? rg : quadrant == 2'h2 ? lvl(p_q3, p_main) : lvl(p_q4, rg);
    endcase
    if (torque_limit_select_input && p_sec != DISABLE_CODE) p = p_sec;
    if (phase == PH_ACCEL) p = mn(p, lvl(p_acc, p));
    if (phase == PH_DECEL) p = mn(p, lvl(p_dec, p));
    return p;
  endfunction

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {wr, rd, small_model, torque_control, vf_control, panel_operation, mains_voltage_present} = '0;
    {undervoltage_raw, power_fail_raw, torque_limit_select_input, run_cmd, option_fitted, not_ready, ipf} = '0;
    {addr, wdata, speed_cmd, speed_act, analog3_abs, analog4, quadrant, phase} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rreg(5'h05, 16'(TLM_RESET));
    wreg(5'h05, 16'h000B);
    rreg(5'h05, 16'(TLM_PARAM_QUAD));
    chk("duty_visible", 16'h0, 16'(duty_visible));
    chk("torque_limit", 16'(TORQUE_MAIN_RESET), 16'(torque_limit));
    rreg(5'h1F, 16'h0);
    wreg(5'h06, 16'h01F4);
    rreg(5'h06, 16'(TORQUE_MAX));
    wreg(5'h00, 16'h1);
    small_model <= 1'b1;
    wreg(5'h01, 16'h1E);
    rreg(5'h01, 16'h1E);
    chk("duty_visible", 16'h1, 16'(duty_visible));
    small_model <= 1'b0;
    cyc(2);
    rreg(5'h01, 16'h0);
    wreg(5'h04, 16'h03E8);
    speed_act <= 14'h047D;
    cyc(5);
    chk("overspeed_error", 16'h0, 16'(overspeed_error));
    speed_act <= 14'h047E;
    cyc(5);
    chk("overspeed_error", 16'h1, 16'(overspeed_error));
    speed_act <= 14'h0;
    wreg(5'h10, 16'h0);
    vf_control <= 1'b1;
    speed_act <= 14'h07D0;
    cyc(5);
    chk("overspeed_error", 16'h0, 16'(overspeed_error));
    vf_control <= 1'b0;
    cyc(5);
    chk("overspeed_error", 16'h1, 16'(overspeed_error));
    speed_act <= 14'h0;
    wreg(5'h10, 16'h0);
    wreg(5'h02, 16'h0064);
    wreg(5'h03, 16'h0);
    run_cmd <= 1'b1;
    speed_cmd <= 14'h01F4;
    torque_control <= 1'b1;
    cyc(12000);
    chk("speed_dev_error", 16'h0, 16'(speed_dev_error));
    torque_control <= 1'b0;
    cyc(9000);
    chk("speed_dev_error", 16'h0, 16'(speed_dev_error));
    cyc(2000);
    chk("speed_dev_error", 16'h1, 16'(speed_dev_error));
    chk("run_enable", 16'h0, 16'(run_enable));
    speed_cmd <= 14'h0;
    wreg(5'h02, 16'(DISABLE_CODE));
    wreg(5'h10, 16'h0);
    not_ready <= 1'b1;
    cyc(5);
    chk("run_enable", 16'h1, 16'(run_enable));
    undervoltage_raw <= 1'b1;
    wreg(5'h00, 16'h3);
    cyc(4);
    chk("run_enable", 16'h0, 16'(run_enable));
    chk("undervoltage_detect", 16'h0, 16'(undervoltage_detect));
    not_ready <= 1'b0;
    cyc(5);
    chk("run_enable", 16'h1, 16'(run_enable));
    mains_voltage_present <= 1'b1;
    wreg(5'h00, 16'h4);
    cyc(5);
    chk("option_error", 16'h1, 16'(option_error));
    mains_voltage_present <= 1'b0;
    wreg(5'h10, 16'h0);
    wreg(5'h0D, 16'h0);
    wreg(5'h0E, 16'h5);
    cyc(4);
    chk("stored_run_cmd", 16'h0, 16'(stored_run_cmd));
    wreg(5'h0D, 16'h2);
    cyc(4);
    chk("stored_run_cmd", 16'h1, 16'(stored_run_cmd));
    wreg(5'h00, 16'h0);
    for (int i = 0; i < 40; i++) begin
      m = 3'(1 + i % 4);
      p_main = 14'($unsigned($random(seed)) % 401);
      p_regen = rv();
      p_q3 = rv();
      p_q4 = rv();
      p_sec = rv();
      p_acc = rv();
      p_dec = rv();
      quadrant <= 2'($random(seed));
      phase <= 2'($unsigned($random(seed)) % 3);
      analog3_abs <= 14'($unsigned($random(seed)) % 500);
      analog4 <= 14'($unsigned($random(seed)) % 500);
      {option_fitted, panel_operation, undervoltage_raw, power_fail_raw, ipf} <= 5'($random(seed));
      torque_limit_select_input <= (m >= TLM_PARAM_QUAD) && 1'($random(seed));
      wreg(5'h05, 16'(m));
      wreg(5'h06, 16'(p_main));
      wreg(5'h07, 16'(p_regen));
      wreg(5'h08, 16'(p_q3));
      wreg(5'h09, 16'(p_q4));
      wreg(5'h0A, 16'(p_sec));
      wreg(5'h0B, 16'(p_dec));
      wreg(5'h0C, 16'(p_acc));
      cyc(4);
      chk("torque_limit", 16'(exp_lim()), 16'(torque_limit));
    end
    conclude();
  end
endmodule
